// ### design/mdd_delineator.sv
/*
  Delineator: receive path splits a packet-zone octet stream into datagrams and strips
  encapsulation headers; send path prepends encapsulation headers or passes datagrams.
  Assumes frame logic delivers the packet zone contiguously, already aligned to a unit start.
*/
`timescale 1ns/100ps
module mdd_delineator (
  input wire logic clk, // 10 MHz
  input wire logic rst_n, // async, active low
  input wire logic rx_valid, // zone octet present
  input wire logic [7:0] rx_data, // zone octet
  output logic rx_ready, // zone octet taken
  output logic out_valid, // delivered octet present
  output logic [7:0] out_data, // delivered octet
  output logic out_first, // first octet of a unit
  output logic out_last, // last octet of a unit
  output logic [1:0] out_kind, // mdd_kind_t of the unit
  input wire logic out_ready, // sink takes octet
  output logic err_version, // pulse: unknown version
  output logic err_length, // pulse: illegal length
  output logic err_protocol, // pulse: reserved protocol dropped
  output logic fill_seen, // pulse: one-octet fill unit
  input wire logic tx_req, // start a unit
  input wire logic tx_encap, // wrap in encapsulation header
  input wire logic tx_fill, // emit one fill octet
  input wire logic [2:0] tx_proto, // carried protocol code
  input wire logic [31:0] tx_len, // payload octets (encap) or total
  output logic tx_req_ready, // request accepted
  input wire logic tx_in_valid, // payload octet present
  input wire logic [7:0] tx_in_data, // payload octet
  output logic tx_in_ready, // payload octet taken
  output logic tx_out_valid, // zone octet present
  output logic [7:0] tx_out_data, // zone octet
  output logic tx_out_last, // last octet of unit
  input wire logic tx_out_ready // frame builder takes octet
);

  typedef struct packed {
    mdd_pkg::mdd_rx_st_t rst;
    mdd_pkg::mdd_kind_t kind;
    logic [31:0] cnt;
    logic [31:0] tot;
    logic [2:0] nl;
    logic drop;
    logic o_valid;
    logic [7:0] o_data;
    logic o_first;
    logic o_last;
    logic [1:0] o_kind;
    logic e_ver;
    logic e_len;
    logic e_proto;
    logic f_seen;
    mdd_pkg::mdd_tx_st_t tst;
    logic [39:0] thdr;
    logic [2:0] thn;
    logic [31:0] trem;
    logic t_valid;
    logic [7:0] t_data;
    logic t_last;
  } mdd_state_t;

  mdd_state_t s;
  mdd_state_t next_s;
  logic acc;
  logic tx_go;
  logic [31:0] idx1;
  logic [31:0] ntot;
  logic [2:0] tnl;
  logic [31:0] ttot;
  logic [7:0] tb0;

  assign rx_ready = !s.o_valid || out_ready;
  assign acc = rx_valid && rx_ready;
  assign tx_go = !s.t_valid || tx_out_ready;
  assign tx_req_ready = s.tst == mdd_pkg::MDD_T_IDLE;
  assign tx_in_ready = (s.tst == mdd_pkg::MDD_T_BODY) && tx_go;
  assign out_valid = s.o_valid;
  assign out_data = s.o_data;
  assign out_first = s.o_first;
  assign out_last = s.o_last;
  assign out_kind = s.o_kind;
  assign err_version = s.e_ver;
  assign err_length = s.e_len;
  assign err_protocol = s.e_proto;
  assign fill_seen = s.f_seen;
  assign tx_out_valid = s.t_valid;
  assign tx_out_data = s.t_data;
  assign tx_out_last = s.t_last;

  //////////////////////////////////////////////////////////////////////////////
  // receive path: state persists across zone boundaries, so units may span them

  always_comb begin
    next_s = s;
    idx1 = s.cnt + 32'h00000001;
    ntot = {s.tot[23:0], rx_data};
    tnl = mdd_pkg::mdd_len_octets(mdd_pkg::mdd_len_code(tx_len));
    ttot = tx_len + 32'h00000001 + {29'h0, tnl};
    tb0 = {mdd_pkg::VER_ENC, tx_proto, mdd_pkg::mdd_len_code(tx_len)};
    next_s.e_ver = 1'b0;
    next_s.e_len = 1'b0;
    next_s.e_proto = 1'b0;
    next_s.f_seen = 1'b0;
    if (s.o_valid && out_ready) begin
      next_s.o_valid = 1'b0;
    end
    if (acc) begin
      next_s.cnt = idx1;
      next_s.o_data = rx_data;
      next_s.o_first = 1'b0;
      next_s.o_last = 1'b0;
      unique case (s.rst)
        mdd_pkg::MDD_R_IDLE: begin
          next_s.cnt = 32'h00000001;
          next_s.drop = 1'b0;
          // version sits in bits 0-2, the top of the first octet
          if (rx_data[7:5] == mdd_pkg::VER_SNP) begin
            next_s.kind = mdd_pkg::MDD_KIND_SNP;
            next_s.tot = {27'h0, rx_data[4:0]};
            next_s.rst = mdd_pkg::MDD_R_DGRAM;
            next_s.o_valid = 1'b1;
            next_s.o_first = 1'b1;
            next_s.o_kind = mdd_pkg::MDD_KIND_SNP;
          end else if (rx_data[7:5] == mdd_pkg::VER_IPV4) begin // fourth bit not looked at
            next_s.kind = mdd_pkg::MDD_KIND_IPV4;
            next_s.tot = 32'h00000000;
            next_s.rst = mdd_pkg::MDD_R_DGRAM;
            next_s.o_valid = 1'b1;
            next_s.o_first = 1'b1;
            next_s.o_kind = mdd_pkg::MDD_KIND_IPV4;
          end else if (rx_data[7:5] == mdd_pkg::VER_ENC) begin
            next_s.kind = mdd_pkg::MDD_KIND_ENC;
            next_s.nl = mdd_pkg::mdd_len_octets(rx_data[1:0]);
            next_s.tot = 32'h00000000;
            // payload kept only for the two carried protocols
            next_s.drop = (rx_data[4:2] != mdd_pkg::PROTO_IPV6) && (rx_data[4:2] != mdd_pkg::PROTO_OCTETS);
            next_s.e_proto = (rx_data[4:2] != mdd_pkg::PROTO_IPV6) && (rx_data[4:2] != mdd_pkg::PROTO_OCTETS)
              && (rx_data[4:2] != mdd_pkg::PROTO_FILL);
            if (rx_data[1:0] == mdd_pkg::LSZ_NONE) begin
              next_s.f_seen = 1'b1; // one-octet unit, next octet starts a new unit
              next_s.e_proto = 1'b0;
            end else begin
              next_s.rst = mdd_pkg::MDD_R_EHDR;
            end
          end else begin
            next_s.e_ver = 1'b1; // octet discarded; the next octet is tried as a unit start
          end
        end
        mdd_pkg::MDD_R_DGRAM: begin
          if ((s.kind == mdd_pkg::MDD_KIND_SNP && s.cnt == mdd_pkg::SNP_LEN_LO_IDX)
              || (s.kind == mdd_pkg::MDD_KIND_IPV4
              && (s.cnt == mdd_pkg::IPV4_LEN_HI_IDX || s.cnt == mdd_pkg::IPV4_LEN_LO_IDX))) begin
            next_s.tot = ntot;
          end
          next_s.o_valid = 1'b1;
          next_s.o_kind = s.kind;
          // total is final once the length octets are in; before that it is not compared
          if ((s.kind == mdd_pkg::MDD_KIND_SNP && s.cnt >= mdd_pkg::SNP_LEN_LO_IDX)
              || (s.kind == mdd_pkg::MDD_KIND_IPV4 && s.cnt >= mdd_pkg::IPV4_LEN_LO_IDX)) begin
            if (next_s.tot <= idx1) begin
              next_s.o_last = 1'b1;
              next_s.e_len = next_s.tot < idx1;
              next_s.rst = mdd_pkg::MDD_R_IDLE;
            end
          end
        end
        mdd_pkg::MDD_R_EHDR: begin
          next_s.tot = ntot; // length field from bit 8, most significant octet first
          if (s.cnt == {29'h0, s.nl}) begin
            // whole-unit count: header is nl+1 octets
            if (ntot < mdd_pkg::ENC_MIN_TOTAL || ntot < idx1) begin
              next_s.e_len = 1'b1;
              next_s.rst = mdd_pkg::MDD_R_IDLE;
            end else if (ntot == idx1) begin
              next_s.rst = mdd_pkg::MDD_R_IDLE;
            end else begin
              next_s.rst = mdd_pkg::MDD_R_EBODY; // payload starts on the very next octet
            end
          end
        end
        mdd_pkg::MDD_R_EBODY: begin
          next_s.o_valid = !s.drop; // header stripped, only payload leaves
          next_s.o_kind = mdd_pkg::MDD_KIND_ENC;
          next_s.o_first = s.cnt == {29'h0, s.nl} + 32'h00000001;
          next_s.o_last = idx1 == s.tot;
          if (idx1 == s.tot) begin
            next_s.rst = mdd_pkg::MDD_R_IDLE;
          end
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // send path

    if (s.t_valid && tx_out_ready) begin
      next_s.t_valid = 1'b0;
    end
    unique case (s.tst)
      mdd_pkg::MDD_T_IDLE: begin
        if (tx_req) begin
          if (tx_fill) begin
            next_s.thdr = {mdd_pkg::FILL_OCTET, 32'h0};
            next_s.thn = 3'h1;
            next_s.trem = 32'h0;
            next_s.tst = mdd_pkg::MDD_T_HDR;
          end else if (tx_encap) begin
            // smallest length field that holds the total; total is at least 2
            unique case (tnl)
              3'h1: next_s.thdr = {tb0, ttot[7:0], 24'h0};
              3'h2: next_s.thdr = {tb0, ttot[15:0], 16'h0};
              default: next_s.thdr = {tb0, ttot};
            endcase
            next_s.thn = tnl + 3'h1;
            next_s.trem = tx_len;
            next_s.tst = mdd_pkg::MDD_T_HDR;
          end else if (tx_len != 32'h0) begin
            next_s.trem = tx_len; // direct datagrams go unwrapped
            next_s.tst = mdd_pkg::MDD_T_BODY;
          end
        end
      end
      mdd_pkg::MDD_T_HDR: begin
        if (tx_go) begin
          next_s.t_valid = 1'b1;
          next_s.t_data = s.thdr[39:32];
          next_s.thdr = {s.thdr[31:0], 8'h0};
          next_s.thn = s.thn - 3'h1;
          next_s.t_last = (s.thn == 3'h1) && (s.trem == 32'h0);
          if (s.thn == 3'h1) begin
            // payload follows the last length octet with no gap
            next_s.tst = (s.trem == 32'h0) ? mdd_pkg::MDD_T_IDLE : mdd_pkg::MDD_T_BODY;
          end
        end
      end
      mdd_pkg::MDD_T_BODY: begin
        if (tx_go && tx_in_valid) begin
          next_s.t_valid = 1'b1;
          next_s.t_data = tx_in_data;
          next_s.trem = s.trem - 32'h1;
          next_s.t_last = s.trem == 32'h1;
          if (s.trem == 32'h1) begin
            next_s.tst = mdd_pkg::MDD_T_IDLE;
          end
        end
      end
      default: next_s.tst = mdd_pkg::MDD_T_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rx_start(logic [2:0] v);
    acc && s.rst == mdd_pkg::MDD_R_IDLE && rx_data[7:5] == v;
  endsequence

  property p_snp_class;
    s_rx_start(mdd_pkg::VER_SNP) |=> out_valid && out_first && out_kind == mdd_pkg::MDD_KIND_SNP;
  endproperty
  a_snp_class: assert property (p_snp_class) else $error("network datagram not classified");

  property p_ipv4_class;
    s_rx_start(mdd_pkg::VER_IPV4) |=> out_valid && out_kind == mdd_pkg::MDD_KIND_IPV4 && s.rst == mdd_pkg::MDD_R_DGRAM;
  endproperty
  a_ipv4_class: assert property (p_ipv4_class) else $error("ipv4 not classified");

  property p_bad_version;
    acc && s.rst == mdd_pkg::MDD_R_IDLE && rx_data[7:5] != mdd_pkg::VER_SNP && rx_data[7:5] != mdd_pkg::VER_IPV4
      && rx_data[7:5] != mdd_pkg::VER_ENC |=> err_version && !out_first && s.rst == mdd_pkg::MDD_R_IDLE;
  endproperty
  a_bad_version: assert property (p_bad_version) else $error("unknown version forwarded");

  property p_fill_one_octet;
    s_rx_start(mdd_pkg::VER_ENC) ##0 rx_data[1:0] == mdd_pkg::LSZ_NONE
      |=> fill_seen && s.rst == mdd_pkg::MDD_R_IDLE && !err_protocol;
  endproperty
  a_fill_one_octet: assert property (p_fill_one_octet) else $error("fill octet mishandled");

  property p_snp_length;
    acc && s.rst == mdd_pkg::MDD_R_DGRAM && s.kind == mdd_pkg::MDD_KIND_SNP && s.cnt == mdd_pkg::SNP_LEN_LO_IDX
      |=> s.tot == {19'h0, $past(s.tot[4:0]), $past(rx_data)};
  endproperty
  a_snp_length: assert property (p_snp_length) else $error("network length misread");

  property p_enc_short;
    acc && s.rst == mdd_pkg::MDD_R_EHDR && s.cnt == {29'h0, s.nl} && ntot < mdd_pkg::ENC_MIN_TOTAL
      |=> err_length && s.rst == mdd_pkg::MDD_R_IDLE;
  endproperty
  a_enc_short: assert property (p_enc_short) else $error("short encapsulation length accepted");

  property p_reserved_drop;
    acc && s.rst == mdd_pkg::MDD_R_EBODY && s.drop |=> !out_valid;
  endproperty
  a_reserved_drop: assert property (p_reserved_drop) else $error("reserved payload delivered");

  sequence s_tx_hdr_first;
    s.tst == mdd_pkg::MDD_T_IDLE && tx_req && tx_encap && !tx_fill;
  endsequence

  // header octet checked where it is loaded; builder stalls would make the output check unbounded
  property p_tx_version;
    s_tx_hdr_first |=> s.tst == mdd_pkg::MDD_T_HDR && s.thdr[39:37] == mdd_pkg::VER_ENC;
  endproperty
  a_tx_version: assert property (p_tx_version) else $error("sent header lacks version 111");

  property p_tx_no_short;
    s_tx_hdr_first |-> ttot >= mdd_pkg::ENC_MIN_TOTAL && ttot > {29'h0, tnl};
  endproperty
  a_tx_no_short: assert property (p_tx_no_short) else $error("sent length below two");

  property p_tx_no_gap;
    s.tst == mdd_pkg::MDD_T_HDR && s.thn == 3'h1 && tx_go && s.trem != 32'h0 |=> s.tst == mdd_pkg::MDD_T_BODY;
  endproperty
  a_tx_no_gap: assert property (p_tx_no_gap) else $error("gap after header");

endmodule : mdd_delineator

// ### inc/mdd_pkg.sv
/*
  Constants, states and the header helpers of the multiplexed datagram delineator.
  Assumes octet-wide streams, first transmitted bit in the most significant bit of each octet.
*/
// Notes on behaviour
// - bit 0 is the first sent bit; it sits in bit 7 of each octet
// - version 001 in bits 0-2 marks a space network datagram
// - space network datagram: 13-bit total length from bit 3, header included
// - IPv4 carries version 0100; only the first three version bits are compared
// - IPv4: 16-bit total length from bit 16, header included
// - network and IPv4 datagrams go direct; IPv6 and octet groups are encapsulated
// - units of all types pack back to back and may span zone boundaries
// - encapsulation unit carries version 111 in bits 0-2
// - bits 3-5 give carried protocol: 000 fill, 100 IPv6, 111 octets, rest reserved
// - bits 6-7 give length size: 00 none, 01 one, 10 two, 11 four octets
// - length size 00 means a one-octet unit with no payload, usable as fill
// - encapsulation length field starts at bit 8, 0/1/2/4 octets long
// - encapsulation length counts octets of the whole unit, header included
// - lengths zero and one are never generated and are rejected on receipt
// - payload starts right after the last length bit, no gap
// - header prepended on send; header size found from length size code, then stripped
package mdd_pkg;

  localparam logic [2:0] VER_SNP = 3'h1;
  localparam logic [2:0] VER_IPV4 = 3'h2;
  localparam logic [2:0] VER_ENC = 3'h7;
  localparam logic [2:0] PROTO_FILL = 3'h0;
  localparam logic [2:0] PROTO_IPV6 = 3'h4;
  localparam logic [2:0] PROTO_OCTETS = 3'h7;
  localparam logic [1:0] LSZ_NONE = 2'h0;
  localparam logic [1:0] LSZ_ONE = 2'h1;
  localparam logic [1:0] LSZ_TWO = 2'h2;
  localparam logic [1:0] LSZ_FOUR = 2'h3;
  localparam logic [7:0] FILL_OCTET = 8'hE0;
  // octet index of the length field and lowest legal total per datagram kind
  localparam logic [31:0] SNP_LEN_LO_IDX = 32'h00000001;
  localparam logic [31:0] IPV4_LEN_HI_IDX = 32'h00000002;
  localparam logic [31:0] IPV4_LEN_LO_IDX = 32'h00000003;
  localparam logic [31:0] ENC_MIN_TOTAL = 32'h00000002;
  // largest payload that still fits a one- or two-octet length field
  localparam logic [31:0] MAX_PAY_ONE = 32'h000000FD;
  localparam logic [31:0] MAX_PAY_TWO = 32'h0000FFFC;

  typedef enum logic [1:0] {MDD_KIND_SNP, MDD_KIND_IPV4, MDD_KIND_ENC} mdd_kind_t;
  typedef enum logic [1:0] {MDD_R_IDLE, MDD_R_DGRAM, MDD_R_EHDR, MDD_R_EBODY} mdd_rx_st_t;
  typedef enum logic [1:0] {MDD_T_IDLE, MDD_T_HDR, MDD_T_BODY} mdd_tx_st_t;

  function automatic logic [2:0] mdd_len_octets(input logic [1:0] code);
    unique case (code)
      LSZ_NONE: mdd_len_octets = 3'h0;
      LSZ_ONE: mdd_len_octets = 3'h1;
      LSZ_TWO: mdd_len_octets = 3'h2;
      LSZ_FOUR: mdd_len_octets = 3'h4;
    endcase
  endfunction : mdd_len_octets

  function automatic logic [1:0] mdd_len_code(input logic [31:0] pay);
    if (pay <= MAX_PAY_ONE) begin
      mdd_len_code = LSZ_ONE;
    end else if (pay <= MAX_PAY_TWO) begin
      mdd_len_code = LSZ_TWO;
    end else begin
      mdd_len_code = LSZ_FOUR;
    end
  endfunction : mdd_len_code

endpackage : mdd_pkg

// ### test/mdd_frame_model.sv
/*
  Frame logic model: feeds packet-zone octets to the delineator and takes the built zone stream.
  Assumes the bench loads rx_q and reads tx_q; one clock, signals change 1 ns after the rising edge.
*/
`timescale 1ns/100ps
module mdd_frame_model (
  input wire logic clk, // bench clock
  input wire logic rst_n, // async, active low
  output logic rx_valid, // zone octet present
  output logic [7:0] rx_data, // zone octet
  input wire logic rx_ready, // taken by delineator
  input wire logic tx_out_valid, // built octet present
  input wire logic [7:0] tx_out_data, // built octet
  input wire logic tx_out_last, // unit end
  output logic tx_out_ready // builder takes octet
);
  logic [7:0] rx_q[$];
  logic [8:0] tx_q[$];
  logic rx_acc = 1'b0;
  logic tx_acc = 1'b0;
  int stall = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_out_ready = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // judged mid-cycle, so the edge itself never races with the design
  always @(negedge clk) begin
    rx_acc = rst_n && rx_valid && rx_ready;
    tx_acc = rst_n && tx_out_valid && tx_out_ready;
    if (tx_acc) begin
      tx_q.push_back({tx_out_last, tx_out_data});
    end
  end
  always @(posedge clk) begin
    #1;
    stall = stall + 1;
    // slow builder: one stall in three cycles
    tx_out_ready = rst_n && (stall % 3 != 0);
    if (!rst_n) begin
      rx_valid = 1'b0;
    end else if (rx_acc || !rx_valid) begin
      if (rx_q.size() > 0) begin
        rx_valid = 1'b1;
        rx_data = rx_q.pop_front();
      end else begin
        // released line keeps changing, never shows a stale octet
        rx_valid = 1'b0;
        rx_data = ~rx_data;
      end
    end
  end
endmodule : mdd_frame_model

// ### test/tb.sv
/*
  Self-checking bench of the delineator: receive and send paths against the frame logic model.
  Assumes a 10 MHz clock and inputs moved 1 ns after each rising edge.
*/
`timescale 1ns/100ps
module tb;
  logic clk, rst_n, rx_valid, rx_ready, out_valid, out_first, out_last, out_ready;
  logic [7:0] rx_data, out_data, tx_in_data, tx_out_data;
  logic [1:0] out_kind;
  logic err_version, err_length, err_protocol, fill_seen;
  logic tx_req, tx_encap, tx_fill, tx_req_ready, tx_in_valid, tx_in_ready;
  logic tx_out_valid, tx_out_last, tx_out_ready;
  logic [2:0] tx_proto;
  logic [31:0] tx_len;
  logic [11:0] out_q[$];
  logic [11:0] exr[$];
  logic [8:0] ex_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int n_fill = 0, n_ev = 0, n_el = 0, n_ep = 0;
  mdd_delineator dut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .out_valid(out_valid), .out_data(out_data), .out_first(out_first), .out_last(out_last), .out_kind(out_kind),
    .out_ready(out_ready), .err_version(err_version), .err_length(err_length), .err_protocol(err_protocol),
    .fill_seen(fill_seen), .tx_req(tx_req), .tx_encap(tx_encap), .tx_fill(tx_fill), .tx_proto(tx_proto),
    .tx_len(tx_len), .tx_req_ready(tx_req_ready), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
    .tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
    .tx_out_last(tx_out_last), .tx_out_ready(tx_out_ready));
  mdd_frame_model fb (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .tx_out_last(tx_out_last),
    .tx_out_ready(tx_out_ready));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // delivered octets and one-cycle flags, sampled mid-cycle
  always @(negedge clk) begin
    if (rst_n === 1'b1) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        out_q.push_back({out_kind, out_first, out_last, out_data});
      end
      if (fill_seen === 1'b1) n_fill++;
      if (err_version === 1'b1) n_ev++;
      if (err_length === 1'b1) n_el++;
      if (err_protocol === 1'b1) n_ep++;
    end
  end
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  task automatic cmp_octet(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: octet %h, expected %h", $time, got, exp);
    end
  endtask : cmp_octet
  task automatic cmp_count(input int got, input int exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : cmp_count
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  function automatic logic [11:0] ent(input logic [1:0] k, input logic f, input logic l, input logic [7:0] d);
    ent = {k, f, l, d};
  endfunction : ent
  // waits until the model has sent everything, then compares the delivered units
  task automatic rx_check();
    for (int i = 0; i < 300 && (fb.rx_q.size() != 0 || rx_valid); i++) cyc(1);
    cyc(6);
    cmp_count(out_q.size(), exr.size());
    for (int i = 0; i < out_q.size() && i < exr.size(); i++) cmp_octet(out_q[i], exr[i]);
    out_q.delete();
    exr.delete();
  endtask : rx_check
  task automatic tx_unit(input logic enc, input logic fl, input logic [2:0] pr, input logic [31:0] len,
                         input int n, input logic [7:0] base);
    logic r;
    int k;
    k = 0;
    tx_req = 1'b1;
    tx_encap = enc;
    tx_fill = fl;
    tx_proto = pr;
    tx_len = len;
    do begin
      @(negedge clk) r = tx_req_ready;
      cyc(1);
    end while (!r && ++k < 100);
    tx_req = 1'b0;
    for (int i = 0; i < n; i++) begin
      tx_in_valid = 1'b1;
      tx_in_data = base + 8'(i);
      k = 0;
      do begin
        @(negedge clk) r = tx_in_ready;
        cyc(1);
      end while (!r && ++k < 100);
    end
    tx_in_valid = 1'b0;
    for (k = 0; k < 2000 && fb.tx_q.size() < ex_q.size(); k++) cyc(1);
    cyc(3);
    cmp_count(fb.tx_q.size(), ex_q.size());
    for (int i = 0; i < fb.tx_q.size() && i < ex_q.size(); i++) cmp_octet({3'h0, fb.tx_q[i]}, {3'h0, ex_q[i]});
    fb.tx_q.delete();
    ex_q.delete();
  endtask : tx_unit
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_rx_encap();
    out_ready = 1'b0;
    // octet group with one length octet, ipv6 with two, ipv6 with four
    fb.rx_q = '{8'hFD, 8'h03, 8'hAA, 8'hF2, 8'h00, 8'h05, 8'h11, 8'h22,
                8'hF3, 8'h00, 8'h00, 8'h00, 8'h06, 8'h99};
    cyc(10);
    cmp_count(out_q.size(), 0);
    out_ready = 1'b1;
    exr = '{ent(2'h2, 1, 1, 8'hAA), ent(2'h2, 1, 0, 8'h11), ent(2'h2, 0, 1, 8'h22), ent(2'h2, 1, 1, 8'h99)};
    rx_check();
    $display("test rx_encap done");
  endtask : t_rx_encap
  task automatic t_rx_dgram();
    // ipv4 lead octet 0101: fourth version bit set on purpose
    fb.rx_q = '{8'h20, 8'h03, 8'h55, 8'h5F, 8'h00, 8'h00, 8'h04, 8'hFD, 8'h03, 8'h66};
    exr = '{ent(2'h0, 1, 0, 8'h20), ent(2'h0, 0, 0, 8'h03), ent(2'h0, 0, 1, 8'h55),
            ent(2'h1, 1, 0, 8'h5F), ent(2'h1, 0, 0, 8'h00), ent(2'h1, 0, 0, 8'h00), ent(2'h1, 0, 1, 8'h04),
            ent(2'h2, 1, 1, 8'h66)};
    rx_check();
    $display("test rx_dgram done");
  endtask : t_rx_dgram
  task automatic t_rx_events();
    n_fill = 0;
    n_ev = 0;
    n_el = 0;
    n_ep = 0;
    // illegal length last: resync after it is not defined
    fb.rx_q = '{8'hE0, 8'hE0, 8'h80, 8'hE9, 8'h03, 8'h77, 8'hFD, 8'h01};
    rx_check();
    cmp_count(n_fill, 2);
    cmp_count(n_ev, 1);
    cmp_count(n_ep, 1);
    cmp_count(n_el, 1);
    $display("test rx_events done");
  endtask : t_rx_events
  task automatic t_tx();
    ex_q = '{9'h0FD, 9'h003, 9'h13C};
    tx_unit(1'b1, 1'b0, 3'h7, 32'h00000001, 1, 8'h3C);
    ex_q = '{9'h1E0};
    tx_unit(1'b1, 1'b1, 3'h0, 32'h00000000, 0, 8'h00);
    ex_q = '{9'h020, 9'h021, 9'h122};
    tx_unit(1'b0, 1'b0, 3'h0, 32'h00000003, 3, 8'h20);
    // 300 payload + 1 + 2 length octets = 303 = 012F
    ex_q = '{9'h0F2, 9'h001, 9'h02F};
    for (int i = 0; i < 300; i++) ex_q.push_back({i == 299, 8'(i)});
    tx_unit(1'b1, 1'b0, 3'h4, 32'h0000012C, 300, 8'h00);
    $display("test tx done");
  endtask : t_tx
  initial begin
    rst_n = 1'b0;
    out_ready = 1'b1;
    tx_req = 1'b0;
    tx_encap = 1'b0;
    tx_fill = 1'b0;
    tx_proto = 3'h0;
    tx_len = 32'h00000000;
    tx_in_valid = 1'b0;
    tx_in_data = 8'h00;
    cyc(3);
    rst_n = 1'b1;
    t_rx_encap();
    t_rx_dgram();
    t_rx_events();
    t_tx();
    final_report();
  end
  initial begin
    #(6000 * 100);
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end
endmodule : tb
